// ===== sram_snooze_pkg.sv
// Shared constants, types and the register map of the snooze-capable burst SRAM.
`default_nettype none
package sram_snooze_pkg;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;
  localparam int ADDR_W_DEF = 8;
  localparam int AXI_AW = 4;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [AXI_AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 4'h4;
  // Field positions.
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int STAT_SNOOZE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_CNT_LSB = 2;
  // Reset values and bus answers.
  localparam logic CTRL_SLEEP_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Sleep timing in clock cycles, then the burst counter constants.
  localparam int SNOOZE_ENTRY_MAX_CYC = 2;
  localparam int WAKE_GUARD_CYC = 2;
  localparam logic [BURST_W-1:0] CNT_ONE = 2'h1;
  localparam logic [BURST_W-1:0] CNT_ZERO = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11
  } burst_state_e;

  // Clocked control pins; all strobes and selects are active low except the high select.
  typedef struct packed {
    logic chip_select_low_a_n;
    logic chip_select_high;
    logic chip_select_low_b_n;
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic byte_write_enable_n;
    logic [LANES-1:0] byte_write_lanes_n;
  } sram_ctrl_s;
endpackage : sram_snooze_pkg
`default_nettype wire

// ===== sram_snooze_burst.sv
// Flow-through burst SRAM core with snooze control and an AXI4-Lite control slave.
//
// Overview of operation
// - Once sleep is requested the core stops acting on its clocked inputs from the first edge of the request.
// - After sleep is requested the core is in snooze within at most two cycles.
// - Leaving snooze takes no delay once the sleep request drops.
// - Strobes load only while the chip is enabled, else they deselect; burst continuation cycles ignore the selects.
// - Burst order is XOR with the count when the order select is high, addition when low.
// - In a cycle started by the controller strobe the burst-advance input is ignored.
`default_nettype none
module sram_snooze_burst #(
  parameter int ADDR_W = sram_snooze_pkg::ADDR_W_DEF
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SLEEP_REQUEST,
  input wire logic BURST_ORDER_SELECT,
  input wire sram_snooze_pkg::sram_ctrl_s SRAM_CTRL,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [sram_snooze_pkg::DATA_W-1:0] DQ_IN,
  output logic [sram_snooze_pkg::DATA_W-1:0] DQ_OUT,
  output logic DQ_OE,
  output logic SNOOZE_ACTIVE,
  input wire logic [sram_snooze_pkg::AXI_AW-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [sram_snooze_pkg::AXI_AW-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import sram_snooze_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Burst engine and array.

  burst_state_e state_ff, nxt_state;
  logic [BURST_W-1:0] cnt_ff, nxt_cnt;
  logic [ADDR_W-1:0] base_ff, nxt_base;
  logic order_ff, nxt_order;
  logic snooze_ff, nxt_snooze;
  logic [DATA_W-1:0] dq_ff, nxt_dq;
  logic oe_ff, nxt_oe;
  logic sw_sleep_ff;
  logic sleep_eff, gate, chip_en, strobe_p, strobe_c, load, desel, burst_advance;
  logic [LANES-1:0] lanes_req, mem_we;
  logic [BURST_W-1:0] low_bits;
  logic [ADDR_W-1:0] acc_addr;
  // One array per lane, so that each lane's write process owns its own storage.
  logic [LANE_W-1:0] mem_lane [LANES][2**ADDR_W];

  // Decode of one clock's pins into the access performed at this edge.
  always_comb begin
    sleep_eff = SLEEP_REQUEST | sw_sleep_ff;
    // Inputs are dropped from the first edge of the request; the extra cycle after
    // release covers the guard that the controller keeps anyway.
    gate = sleep_eff | snooze_ff;
    chip_en = !SRAM_CTRL.chip_select_low_a_n & SRAM_CTRL.chip_select_high &
              !SRAM_CTRL.chip_select_low_b_n;
    strobe_p = !SRAM_CTRL.processor_address_strobe_n;
    strobe_c = !SRAM_CTRL.controller_address_strobe_n & !strobe_p;
    load = !gate & chip_en & (strobe_p | strobe_c);
    desel = !gate & !chip_en & (strobe_p | strobe_c);
    // A strobe cycle takes priority, so advance has no effect there.
    burst_advance = !gate & (state_ff != ST_IDLE) & !load & !desel &
          !SRAM_CTRL.burst_advance_n;
    if (!SRAM_CTRL.global_write_n) begin
      lanes_req = '1;
    end else if (!SRAM_CTRL.byte_write_enable_n) begin
      lanes_req = ~SRAM_CTRL.byte_write_lanes_n;
    end else begin
      lanes_req = '0;
    end
    nxt_cnt = load ? CNT_ZERO : (burst_advance ? cnt_ff + CNT_ONE : cnt_ff);
    nxt_base = load ? ADDR : base_ff;
    nxt_order = load ? BURST_ORDER_SELECT : order_ff;
    low_bits = nxt_order ? (nxt_base[BURST_W-1:0] ^ nxt_cnt)
                         : (nxt_base[BURST_W-1:0] + nxt_cnt);
    acc_addr = {nxt_base[ADDR_W-1:BURST_W], low_bits};
    nxt_state = state_ff;
    mem_we = '0;
    if (load && strobe_p) begin
      nxt_state = ST_READ;
    end else if (load || (!gate && !desel && state_ff != ST_IDLE)) begin
      nxt_state = (|lanes_req) ? ST_WRITE : ST_READ;
      mem_we = lanes_req;
    end else if (desel) begin
      nxt_state = ST_IDLE;
    end
    nxt_oe = !gate & (nxt_state == ST_READ) & (load | state_ff != ST_IDLE);
    nxt_dq = dq_ff;
    if (nxt_oe) begin
      for (int ln = 0; ln < LANES; ln++) begin
        nxt_dq[ln*LANE_W +: LANE_W] = mem_lane[ln][acc_addr];
      end
    end
    nxt_snooze = sleep_eff;
  end

  // Control registers of the burst engine.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_ZERO;
      base_ff <= '0;
      order_ff <= 1'b1;
      snooze_ff <= 1'b0;
      dq_ff <= '0;
      oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      base_ff <= nxt_base;
      order_ff <= nxt_order;
      snooze_ff <= nxt_snooze;
      dq_ff <= nxt_dq;
      oe_ff <= nxt_oe;
    end
  end

  // The array has no reset and no path that snooze touches, so data survive sleep.
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    always_ff @(posedge REF_CLK) begin
      if (mem_we[l]) begin
        mem_lane[l][acc_addr] <= DQ_IN[l*LANE_W +: LANE_W];
      end
    end
  end

  assign DQ_OUT = dq_ff;
  assign DQ_OE = oe_ff;
  // Exit is combinational so that the low-power flag drops with the pin.
  assign SNOOZE_ACTIVE = snooze_ff & sleep_eff;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok;
  logic [AXI_AW-1:0] aw_addr_ff, nxt_aw_addr, wr_addr;
  logic [31:0] w_data_ff, nxt_w_data, wr_data, nxt_rdata;
  logic w_strb0_ff, nxt_w_strb0, wr_strb0;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid, nxt_sw_sleep;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, status_word;
  logic aw_now, w_now, do_wr;

  assign AWREADY = !aw_ok_ff & !bvalid_ff;
  assign WREADY = !w_ok_ff & !bvalid_ff;
  assign ARREADY = !rvalid_ff;

  // Address and data may arrive in either order; the write completes when both are held.
  always_comb begin
    aw_now = aw_ok_ff | (AWVALID & AWREADY);
    w_now = w_ok_ff | (WVALID & WREADY);
    wr_addr = aw_ok_ff ? aw_addr_ff : AWADDR;
    wr_data = w_ok_ff ? w_data_ff : WDATA;
    wr_strb0 = w_ok_ff ? w_strb0_ff : WSTRB[0];
    do_wr = aw_now & w_now;
    nxt_aw_ok = aw_now & !do_wr;
    nxt_w_ok = w_now & !do_wr;
    nxt_aw_addr = wr_addr;
    nxt_w_data = wr_data;
    nxt_w_strb0 = wr_strb0;
    nxt_bvalid = do_wr | (bvalid_ff & !BREADY);
    nxt_bresp = bresp_ff;
    nxt_sw_sleep = sw_sleep_ff;
    if (do_wr) begin
      if (wr_addr[AXI_AW-1:2] == OFS_CTRL[AXI_AW-1:2]) begin
        nxt_bresp = RESP_OKAY;
        if (wr_strb0) begin
          nxt_sw_sleep = wr_data[CTRL_SLEEP_BIT];
        end
      end else begin
        nxt_bresp = RESP_SLVERR;
      end
    end
    status_word = '0;
    status_word[STAT_SNOOZE_BIT] = SNOOZE_ACTIVE;
    status_word[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
    status_word[STAT_CNT_LSB +: BURST_W] = cnt_ff;
    nxt_rvalid = (ARVALID & ARREADY) | (rvalid_ff & !RREADY);
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (ARVALID && ARREADY) begin
      nxt_rresp = RESP_OKAY;
      nxt_rdata = '0;
      if (ARADDR[AXI_AW-1:2] == OFS_CTRL[AXI_AW-1:2]) begin
        nxt_rdata[CTRL_SLEEP_BIT] = sw_sleep_ff;
      end else if (ARADDR[AXI_AW-1:2] == OFS_STATUS[AXI_AW-1:2]) begin
        nxt_rdata = status_word;
      end else begin
        nxt_rresp = RESP_SLVERR;
      end
    end
  end

  // Bus-side registers.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
      sw_sleep_ff <= CTRL_SLEEP_RST;
    end else begin
      aw_ok_ff <= nxt_aw_ok;
      w_ok_ff <= nxt_w_ok;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_strb0_ff <= nxt_w_strb0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      sw_sleep_ff <= nxt_sw_sleep;
    end
  end

  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;
  assign RVALID = rvalid_ff;
  assign RDATA = rdata_ff;
  assign RRESP = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  chk_sleep_no_load: assert property (sleep_eff |-> !load && !burst_advance)
    else $error("command acted on while sleep requested");
  chk_snooze_entry: assert property (sleep_eff [*2] |-> ##[0:1] SNOOZE_ACTIVE)
    else $error("snooze not entered within two cycles");
  chk_snooze_exit: assert property ($fell(sleep_eff) |-> !SNOOZE_ACTIVE)
    else $error("snooze held after sleep released");
  chk_sleep_array_frozen: assert property (snooze_ff |-> mem_we == '0)
    else $error("array written during snooze");
  chk_select_gates: assert property (!chip_en |-> !load)
    else $error("strobe taken while chip disabled");
  chk_strobe_no_adv: assert property (load |=> cnt_ff == CNT_ZERO)
    else $error("advance acted on in a strobe cycle");
  chk_burst_step: assert property (burst_advance |=> cnt_ff == $past(cnt_ff) + CNT_ONE &&
                                   base_ff == $past(base_ff))
    else $error("burst count did not step by one");
  chk_burst_xor: assert property (load && BURST_ORDER_SELECT ##1 burst_advance && !SLEEP_REQUEST
                                  |-> acc_addr[1:0] == (base_ff[1:0] ^ CNT_ONE))
    else $error("interleaved order wrong");
  chk_burst_linear: assert property (load && !BURST_ORDER_SELECT ##1 burst_advance && !SLEEP_REQUEST
                                     |-> acc_addr[1:0] == base_ff[1:0] + CNT_ONE)
    else $error("linear order wrong");
  chk_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");
  chk_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data changed before taken");

  cov_snooze_cycle: cover property (sleep_eff [*3] ##1 !sleep_eff ##2 load);
  cov_burst_wrap: cover property (burst_advance && cnt_ff == 2'h3);
  cov_linear_write: cover property (load && !BURST_ORDER_SELECT && |mem_we);
  cov_sw_sleep: cover property (do_wr && sw_sleep_ff == 1'b0 ##1 sw_sleep_ff);
endmodule : sram_snooze_burst
`default_nettype wire

// ===== sram_host_model.sv
// Memory controller model that drives the clocked pins of the burst SRAM.
`default_nettype none
module sram_host_model (
  input wire logic clk,
  output sram_snooze_pkg::sram_ctrl_s ctl,
  output logic [7:0] addr,
  output logic [17:0] din
);
  timeunit 1ns;
  timeprecision 100ps;
  import sram_snooze_pkg::*;
  // Start deselected with all strobes high.
  initial begin
    ctl = sram_ctrl_s'(10'h2ff);
    addr = 8'h00;
    din = 18'h00000;
  end
  // One enabled cycle; every pin holds until the rising edge that samples it.
  task automatic cyc(input logic ps, cs, burst_advance, wr, input logic [7:0] a, input logic [17:0] d);
    ctl <= '{1'b0, 1'b1, 1'b0, ps, cs, burst_advance, !wr, 1'b1, 2'b11};
    addr <= a;
    din <= wr ? d : ~din; // Idle data toggles so a stale value never looks valid.
    @(posedge clk);
  endtask : cyc
  // A deselected cycle; the address stays put across the edge.
  task automatic idle();
    ctl <= sram_ctrl_s'(10'h2ff);
    din <= ~din;
    @(posedge clk);
  endtask : idle
  // Byte-lane write started by the controller strobe; global write stays off.
  task automatic lane_wr(input logic [1:0] ln, input logic [7:0] a, input logic [17:0] d);
    ctl <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, ln};
    addr <= a;
    din <= d;
    @(posedge clk);
  endtask : lane_wr
  // Controller strobe with the chip disabled: a deselect, which ends any burst.
  task automatic desel(input logic [7:0] a);
    ctl <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'b11};
    addr <= a;
    din <= ~din;
    @(posedge clk);
  endtask : desel
  // After sleep drops, only deselected cycles until the guard has passed.
  task automatic wake();
    repeat (WAKE_GUARD_CYC) idle();
  endtask : wake
endmodule : sram_host_model
`default_nettype wire

// ===== test_sram_snooze_burst.sv
// Self-checking bench for the snooze-capable burst SRAM core.
`default_nettype none
module test_sram_snooze_burst;
  timeunit 1ns;
  timeprecision 100ps;
  import sram_snooze_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep = 1'b0;
  logic order = 1'b1;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [3:0] wstrb = 4'hf;
  logic bready = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rd, val;
  logic [1:0] br, rr, rsp;
  logic awr, wr_rdy, bv, arr, rv, oe, snz;
  sram_ctrl_s ctl;
  logic [7:0] addr, b;
  logic [17:0] din, dq, w;
  logic [17:0] mem [256];
  logic [31:0] seed = 32'h24b2ad56;
  int fail_count = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  sram_host_model u_host (.clk(clk), .ctl(ctl), .addr(addr), .din(din));
  sram_snooze_burst dut (.REF_CLK(clk), .RESET_N(rst_n), .SLEEP_REQUEST(sleep),
    .BURST_ORDER_SELECT(order), .SRAM_CTRL(ctl), .ADDR(addr), .DQ_IN(din), .DQ_OUT(dq),
    .DQ_OE(oe), .SNOOZE_ACTIVE(snz), .AWADDR(awaddr), .AWVALID(awv), .AWREADY(awr),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wv), .WREADY(wr_rdy), .BRESP(br), .BVALID(bv),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arv), .ARREADY(arr), .RDATA(rd),
    .RRESP(rr), .RVALID(rv), .RREADY(rready));
  ////////////////////////////////////////////////////////////////////////////////
  // Repeatable xorshift source.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Burst address: only the two low bits move, so linear order wraps inside the group.
  function automatic logic [7:0] ba(input logic [7:0] a, input logic [1:0] k, input logic il);
    return {a[7:2], il ? a[1:0] ^ k : a[1:0] + k};
  endfunction : ba
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  // Every handshake is judged at the rising edge. The response ready comes up one cycle
  // late on purpose, so that a waiting response is seen standing by the hold checks.
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (bv === 1'b1 && bready === 1'b1) begin
        r = br;
        bready <= 1'b0;
        return;
      end
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_rdy === 1'b1) wv <= 1'b0;
      if (n == 1) bready <= 1'b1;
    end
    fail_count++;
    conclude();
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arv <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rv === 1'b1 && rready === 1'b1) begin
        d = rd;
        r = rr;
        rready <= 1'b0;
        return;
      end
      if (arr === 1'b1) arv <= 1'b0;
      if (n == 1) rready <= 1'b1;
    end
    fail_count++;
    conclude();
  endtask : axr
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Register map, refusals and the software sleep bit.
    axr(OFS_CTRL, val, rsp);
    chk("ctrl_reset", val, 32'h0);
    chk("ctrl_resp", rsp, RESP_OKAY);
    axr(4'h8, val, rsp);
    chk("unmapped_data", val, 32'h0);
    chk("unmapped_resp", rsp, RESP_SLVERR);
    axw(OFS_STATUS, 32'h1, rsp);
    chk("status_write", rsp, RESP_SLVERR);
    // A write whose low byte strobe is off must leave the sleep bit alone.
    wstrb <= 4'h0;
    axw(OFS_CTRL, 32'h1, rsp);
    chk("ctrl_write_resp", rsp, RESP_OKAY);
    wstrb <= 4'hf;
    axr(OFS_CTRL, val, rsp);
    chk("strb_masked", val, 32'h0);
    axw(OFS_CTRL, 32'h1, rsp);
    repeat (2) @(posedge clk);
    axr(OFS_STATUS, val, rsp);
    chk("sw_snooze", val[STAT_SNOOZE_BIT], 1'b1);
    axw(OFS_CTRL, 32'h0, rsp);
    #1 chk("sw_wake", snz, 1'b0);
    u_host.wake();
    $display("test registers done");
    // Bursts in both orders from random bases; the first base sits on the wrap corner.
    for (int p = 0; p < 4; p++) begin
      b = (p == 0) ? 8'h03 : 8'(xs());
      @(posedge clk);
      order <= p[0];
      for (int k = 0; k < 4; k++) begin
        w = 18'(xs());
        mem[ba(b, k[1:0], p[0])] = w;
        u_host.cyc(1'b1, k != 0, k == 0, 1'b1, b, w);
      end
      for (int k = 0; k < 5; k++) begin
        u_host.cyc(k != 0, 1'b1, k == 0, 1'b0, b, 18'h0);
        #1 chk("burst_data", dq, mem[ba(b, k[1:0], p[0])]);
        chk("burst_oe", oe, 1'b1);
      end
    end
    $display("test bursts done");
    // A controller-strobe read with advance low must not step the count.
    u_host.cyc(1'b1, 1'b0, 1'b0, 1'b0, b, 18'h0);
    #1 chk("adv_ignored", dq, mem[b]);
    $display("test strobe done");
    // Byte lanes: only the requested lane lands; a disabled-chip strobe ends the burst.
    w = 18'(xs());
    u_host.lane_wr(2'b10, b, w);
    mem[b][8:0] = w[8:0];
    u_host.cyc(1'b0, 1'b1, 1'b1, 1'b0, b, 18'h0);
    #1 chk("lane_write", dq, mem[b]);
    u_host.desel(b);
    #1 chk("desel_oe", oe, 1'b0);
    u_host.cyc(1'b1, 1'b1, 1'b0, 1'b0, b, 18'h0);
    #1 chk("desel_adv", oe, 1'b0);
    $display("test lanes done");
    // Sleep pin: a write at the sleep edge and a read in snooze are both ignored.
    @(posedge clk);
    sleep <= 1'b1;
    u_host.cyc(1'b1, 1'b0, 1'b1, 1'b1, b, ~mem[b]);
    u_host.idle();
    #1 chk("snooze", snz, 1'b1);
    u_host.cyc(1'b0, 1'b1, 1'b1, 1'b0, b, 18'h0);
    #1 chk("oe_asleep", oe, 1'b0);
    @(posedge clk);
    sleep <= 1'b0;
    #1 chk("wake", snz, 1'b0);
    u_host.wake();
    u_host.cyc(1'b0, 1'b1, 1'b1, 1'b0, b, 18'h0);
    #1 chk("retained", dq, mem[b]);
    $display("test snooze done");
    conclude();
  end
endmodule : test_sram_snooze_burst
`default_nettype wire
